/* File: inc/i2cme_pkg.sv */
// Package: constants and types of the I2C controller engine
// Functional notes
// - A probe command addresses every target from 0x08 up to 0x77, both included, and reports each one that acknowledged.
// - Each probe address goes out with the read bit, and a target counts as present only if SDA is low in the following acknowledge slot.
// - A probe is refused unless the engine is configured as bus controller.
// - A start request pulls SDA from high to low while SCL is high.
// - A stop request releases SDA from low to high while SCL is high.
// - A raw read of N bytes clocks in exactly N bytes, with ACK after each byte but the last and NACK after the last.
// - A raw write sends each byte and checks its acknowledge slot, and a missing acknowledge aborts the write with an error.
// - An addressed read fetches exactly the requested number of bytes and reports how many were received.
// - An addressed write sends all bytes, and a per-command option chooses a closing stop or leaves the bus held.
// - Register-style accesses carry both the target bus address and an internal memory address.
// - The internal memory address width is selectable in bits and is eight bits when left unspecified.
// - A register-style write sends target address, memory address, then payload, and reports the count of bytes written.
// - Bus transactions start only while the controller setting is selected.
`default_nettype none
package i2cme_pkg;
  localparam int unsigned CLK_PERIOD_NS    = 40;
  localparam int unsigned SCL_QUARTER_NS   = 2500;
  localparam int unsigned QUARTER_CYC      = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0]  PROBE_FIRST      = 7'h08;
  localparam logic [6:0]  PROBE_LAST       = 7'h77;
  localparam logic [5:0]  MEM_BITS_DEFAULT = 6'h08;
  localparam int unsigned MADDR_W          = 32;
  localparam logic [2:0]  MADDR_BYTES_MAX  = 3'h4;
  localparam logic [2:0]  MB_LAST          = 3'h1;
  localparam int unsigned NB_W             = 16;
  localparam logic [NB_W-1:0] NB_LAST      = 16'h0001;
  localparam logic        DIR_RD           = 1'b1;
  localparam logic        DIR_WR           = 1'b0;
  localparam logic [3:0]  LAST_BIT         = 4'h8;
  localparam logic [7:0]  RD_FILL          = 8'hff;

  typedef enum logic [3:0] {
    OP_PROBE  = 4'h0,
    OP_START  = 4'h1,
    OP_STOP   = 4'h2,
    OP_RAW_RD = 4'h3,
    OP_RAW_WR = 4'h4,
    OP_RD     = 4'h5,
    OP_WR     = 4'h6,
    OP_MEM_RD = 4'h7,
    OP_MEM_WR = 4'h8
  } i2cme_op_t;

  typedef enum logic [1:0] {
    L_START = 2'h0,
    L_STOP  = 2'h1,
    L_BYTE  = 2'h2
  } i2cme_lop_t;

  typedef enum logic [3:0] {
    P_IDLE   = 4'h0,
    P_START  = 4'h1,
    P_ADDR   = 4'h2,
    P_MADDR  = 4'h3,
    P_RSTART = 4'h4,
    P_RADDR  = 4'h5,
    P_WDATA  = 4'h6,
    P_RDATA  = 4'h7,
    P_STOP   = 4'h8
  } i2cme_ph_t;

  typedef struct packed {
    i2cme_op_t          op;
    logic [6:0]         addr;
    logic [MADDR_W-1:0] mem_addr;
    logic [5:0]         mem_bits;
    logic [NB_W-1:0]    nbytes;
    logic               stop;
  } i2cme_cmd_t;
endpackage : i2cme_pkg
`default_nettype wire

/* File: design/i2cme_phy.sv */
// Bit engine: start, stop and nine-bit byte slots on SCL and SDA
`default_nettype none
module i2cme_phy #(
  parameter int unsigned QUARTER = i2cme_pkg::QUARTER_CYC
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  go_i,
  input  wire i2cme_pkg::i2cme_lop_t op_i,
  input  wire logic [7:0]            tx_i,
  input  wire logic                  ack_i,
  input  wire logic                  sda_i,
  output logic                       done_o,
  output logic [7:0]                 rx_o,
  output logic                       nack_o,
  output logic                       scl_o,
  output logic                       scl_oe_o,
  output logic                       sda_o,
  output logic                       sda_oe_o
);
  localparam int unsigned DIV_W = $clog2(QUARTER + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(QUARTER - 1);

  logic                  act_reg, act_next;
  i2cme_pkg::i2cme_lop_t kind_reg, kind_next;
  logic [1:0]            q_reg, q_next;
  logic [DIV_W-1:0]      div_reg, div_next;
  logic [3:0]            bit_reg, bit_next;
  logic [8:0]            sh_reg, sh_next;
  logic [8:0]            rx_reg, rx_next;
  logic                  scl_next, sda_next, done_next;

  assign rx_o   = rx_reg[8:1];
  assign nack_o = rx_reg[0];

  always_comb begin
    act_next  = act_reg;
    kind_next = kind_reg;
    q_next    = q_reg;
    div_next  = div_reg;
    bit_next  = bit_reg;
    sh_next   = sh_reg;
    rx_next   = rx_reg;
    scl_next  = scl_oe_o;
    sda_next  = sda_oe_o;
    done_next = 1'b0;
    if (!act_reg) begin
      if (go_i) begin
        act_next  = 1'b1;
        kind_next = op_i;
        q_next    = 2'h0;
        div_next  = '0;
        bit_next  = 4'h0;
        sh_next   = {tx_i, ~ack_i};
        unique case (op_i)
          i2cme_pkg::L_START: sda_next = 1'b0;
          i2cme_pkg::L_STOP:  sda_next = 1'b1;
          default:            sda_next = ~tx_i[7];
        endcase
      end
    end else if (div_reg != DIV_LAST) begin
      div_next = div_reg + DIV_W'(1);
    end else begin
      div_next = '0;
      q_next   = q_reg + 2'h1;
      unique case (q_reg)
        2'h0: scl_next = 1'b0;
        2'h1: begin
          if (kind_reg == i2cme_pkg::L_START) begin
            sda_next = 1'b1;
          end else if (kind_reg == i2cme_pkg::L_STOP) begin
            sda_next = 1'b0;
          end else begin
            rx_next = {rx_reg[7:0], sda_i};
          end
        end
        2'h2: if (kind_reg != i2cme_pkg::L_STOP) begin
          scl_next = 1'b1;
        end
        2'h3: begin
          if (kind_reg == i2cme_pkg::L_BYTE && bit_reg != i2cme_pkg::LAST_BIT) begin
            bit_next = bit_reg + 4'h1;
            sh_next  = {sh_reg[7:0], 1'b1};
            sda_next = ~sh_reg[7];
          end else begin
            act_next  = 1'b0;
            done_next = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_reg  <= 1'b0;
      kind_reg <= i2cme_pkg::L_START;
      q_reg    <= 2'h0;
      div_reg  <= '0;
      bit_reg  <= 4'h0;
      sh_reg   <= 9'h000;
      rx_reg   <= 9'h000;
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
      done_o   <= 1'b0;
      scl_o    <= 1'b0;
      sda_o    <= 1'b0;
    end else begin
      act_reg  <= act_next;
      kind_reg <= kind_next;
      q_reg    <= q_next;
      div_reg  <= div_next;
      bit_reg  <= bit_next;
      sh_reg   <= sh_next;
      rx_reg   <= rx_next;
      scl_oe_o <= scl_next;
      sda_oe_o <= sda_next;
      done_o   <= done_next;
      scl_o    <= 1'b0;
      sda_o    <= 1'b0;
    end
  end
endmodule : i2cme_phy
`default_nettype wire

/* File: design/i2cme_top.sv */
// Top: command sequencer of the I2C controller engine
`default_nettype none
module i2cme_top #(
  parameter int unsigned QUARTER = i2cme_pkg::QUARTER_CYC
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      ctrl_mode_i,
  input  wire logic                      cmd_valid_i,
  input  wire i2cme_pkg::i2cme_cmd_t     cmd_i,
  output logic                           cmd_ready_o,
  output logic                           cmd_refused_o,
  input  wire logic [7:0]                wr_data_i,
  input  wire logic                      wr_valid_i,
  output logic                           wr_ready_o,
  output logic [7:0]                     rd_data_o,
  output logic                           rd_valid_o,
  output logic                           done_o,
  output logic                           err_o,
  output logic [i2cme_pkg::NB_W-1:0]     count_o,
  output logic                           probe_hit_o,
  output logic [6:0]                     probe_addr_o,
  input  wire logic                      sda_i,
  output logic                           sda_o,
  output logic                           sda_oe_o,
  output logic                           scl_o,
  output logic                           scl_oe_o
);
  localparam int unsigned NB_W = i2cme_pkg::NB_W;
  localparam int unsigned MW   = i2cme_pkg::MADDR_W;

  i2cme_pkg::i2cme_ph_t  ph_reg, ph_next;
  i2cme_pkg::i2cme_op_t  op_reg, op_next;
  logic [6:0]            addr_next;
  logic [MW-1:0]         msh_reg, msh_next;
  logic [2:0]            mb_reg, mb_next;
  logic [NB_W-1:0]       n_reg, n_next;
  logic [NB_W-1:0]       cnt_next;
  logic                  stop_reg, stop_next;
  logic                  err_next, done_next, ready_next, refused_next;
  logic                  wrdy_next, rdv_next, hit_next;
  logic [7:0]            rdd_next;
  logic                  issue, fin, refuse, is_data;
  logic [2:0]            mb_cmd;
  logic [5:0]            mshift;
  logic                  go;
  i2cme_pkg::i2cme_lop_t lop;
  logic [7:0]            ltx;
  logic                  lack;
  logic                  ldone, lnack;
  logic [7:0]            lrx;

  i2cme_phy #(
    .QUARTER (QUARTER)
  ) u_phy (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .go_i     (go),
    .op_i     (lop),
    .tx_i     (ltx),
    .ack_i    (lack),
    .sda_i    (sda_i),
    .done_o   (ldone),
    .rx_o     (lrx),
    .nack_o   (lnack),
    .scl_o    (scl_o),
    .scl_oe_o (scl_oe_o),
    .sda_o    (sda_o),
    .sda_oe_o (sda_oe_o)
  );

  always_comb begin
    mb_cmd  = (cmd_i.mem_bits == 6'h00) ? i2cme_pkg::MEM_BITS_DEFAULT[5:3] : cmd_i.mem_bits[5:3];
    mshift  = {3'(i2cme_pkg::MADDR_BYTES_MAX - mb_cmd), 3'h0};
    is_data = cmd_i.op != i2cme_pkg::OP_PROBE && cmd_i.op != i2cme_pkg::OP_START && cmd_i.op != i2cme_pkg::OP_STOP;
    refuse  = !ctrl_mode_i
            || cmd_i.op > i2cme_pkg::OP_MEM_WR
            || (is_data && cmd_i.nbytes == '0)
            || mb_cmd == 3'h0
            || mb_cmd > i2cme_pkg::MADDR_BYTES_MAX;
  end

  always_comb begin
    ph_next      = ph_reg;
    op_next      = op_reg;
    addr_next    = probe_addr_o;
    msh_next     = msh_reg;
    mb_next      = mb_reg;
    n_next       = n_reg;
    cnt_next     = count_o;
    stop_next    = stop_reg;
    err_next     = err_o;
    ready_next   = cmd_ready_o;
    wrdy_next    = wr_ready_o;
    rdd_next     = rd_data_o;
    refused_next = 1'b0;
    done_next    = 1'b0;
    rdv_next     = 1'b0;
    hit_next     = 1'b0;
    issue        = 1'b0;
    fin          = 1'b0;
    go           = 1'b0;
    lop          = i2cme_pkg::L_BYTE;
    ltx          = i2cme_pkg::RD_FILL;
    lack         = 1'b0;
    unique case (ph_reg)
      i2cme_pkg::P_IDLE: begin
        if (cmd_valid_i && cmd_ready_o) begin
          if (refuse) begin
            refused_next = 1'b1;
          end else begin
            ready_next = 1'b0;
            issue      = 1'b1;
            op_next    = cmd_i.op;
            addr_next  = (cmd_i.op == i2cme_pkg::OP_PROBE) ? i2cme_pkg::PROBE_FIRST : cmd_i.addr;
            msh_next   = cmd_i.mem_addr << mshift;
            mb_next    = mb_cmd;
            n_next     = cmd_i.nbytes;
            stop_next  = cmd_i.stop;
            cnt_next   = '0;
            err_next   = 1'b0;
            unique case (cmd_i.op)
              i2cme_pkg::OP_STOP:   ph_next = i2cme_pkg::P_STOP;
              i2cme_pkg::OP_RAW_RD: ph_next = i2cme_pkg::P_RDATA;
              i2cme_pkg::OP_RAW_WR: ph_next = i2cme_pkg::P_WDATA;
              default:              ph_next = i2cme_pkg::P_START;
            endcase
          end
        end
      end
      i2cme_pkg::P_START: if (ldone) begin
        issue   = op_reg != i2cme_pkg::OP_START;
        fin     = op_reg == i2cme_pkg::OP_START;
        ph_next = i2cme_pkg::P_ADDR;
      end
      i2cme_pkg::P_ADDR: if (ldone) begin
        issue = 1'b1;
        if (op_reg == i2cme_pkg::OP_PROBE) begin
          hit_next = !lnack;
          ph_next  = i2cme_pkg::P_STOP;
        end else if (lnack) begin
          err_next = 1'b1;
          ph_next  = i2cme_pkg::P_STOP;
        end else if (op_reg == i2cme_pkg::OP_RD) begin
          ph_next = i2cme_pkg::P_RDATA;
        end else if (op_reg == i2cme_pkg::OP_WR) begin
          ph_next = i2cme_pkg::P_WDATA;
        end else begin
          ph_next = i2cme_pkg::P_MADDR;
        end
      end
      i2cme_pkg::P_MADDR: if (ldone) begin
        issue = 1'b1;
        if (lnack) begin
          err_next = 1'b1;
          ph_next  = i2cme_pkg::P_STOP;
        end else if (mb_reg != i2cme_pkg::MB_LAST) begin
          mb_next  = mb_reg - 3'h1;
          msh_next = {msh_reg[MW-9:0], 8'h00};
        end else if (op_reg == i2cme_pkg::OP_MEM_RD) begin
          ph_next = i2cme_pkg::P_RSTART;
        end else begin
          ph_next = i2cme_pkg::P_WDATA;
        end
      end
      i2cme_pkg::P_RSTART: if (ldone) begin
        issue   = 1'b1;
        ph_next = i2cme_pkg::P_RADDR;
      end
      i2cme_pkg::P_RADDR: if (ldone) begin
        issue    = 1'b1;
        err_next = lnack;
        ph_next  = lnack ? i2cme_pkg::P_STOP : i2cme_pkg::P_RDATA;
      end
      i2cme_pkg::P_WDATA: begin
        if (wr_ready_o && wr_valid_i) begin
          wrdy_next = 1'b0;
          go        = 1'b1;
          ltx       = wr_data_i;
        end
        if (ldone) begin
          issue = 1'b1;
          if (lnack) begin
            err_next = 1'b1;
            fin      = op_reg == i2cme_pkg::OP_RAW_WR;
            ph_next  = i2cme_pkg::P_STOP;
          end else begin
            cnt_next = count_o + NB_W'(1);
            n_next   = n_reg - NB_W'(1);
            if (n_reg == i2cme_pkg::NB_LAST) begin
              fin     = op_reg == i2cme_pkg::OP_RAW_WR || (op_reg == i2cme_pkg::OP_WR && !stop_reg);
              ph_next = i2cme_pkg::P_STOP;
            end
          end
        end
      end
      i2cme_pkg::P_RDATA: if (ldone) begin
        issue    = 1'b1;
        rdv_next = 1'b1;
        rdd_next = lrx;
        cnt_next = count_o + NB_W'(1);
        n_next   = n_reg - NB_W'(1);
        if (n_reg == i2cme_pkg::NB_LAST) begin
          fin     = op_reg == i2cme_pkg::OP_RAW_RD;
          ph_next = i2cme_pkg::P_STOP;
        end
      end
      i2cme_pkg::P_STOP: if (ldone) begin
        if (op_reg == i2cme_pkg::OP_PROBE && probe_addr_o != i2cme_pkg::PROBE_LAST) begin
          addr_next = probe_addr_o + 7'h01;
          issue     = 1'b1;
          ph_next   = i2cme_pkg::P_START;
        end else begin
          fin = 1'b1;
        end
      end
      default: ph_next = i2cme_pkg::P_IDLE;
    endcase
    if (fin) begin
      issue      = 1'b0;
      ph_next    = i2cme_pkg::P_IDLE;
      ready_next = 1'b1;
      done_next  = 1'b1;
    end
    if (issue) begin
      go = 1'b1;
      unique case (ph_next)
        i2cme_pkg::P_START,
        i2cme_pkg::P_RSTART: lop = i2cme_pkg::L_START;
        i2cme_pkg::P_STOP:   lop = i2cme_pkg::L_STOP;
        i2cme_pkg::P_ADDR:   ltx = {addr_next, (op_reg == i2cme_pkg::OP_PROBE || op_reg == i2cme_pkg::OP_RD) ?
                                    i2cme_pkg::DIR_RD : i2cme_pkg::DIR_WR};
        i2cme_pkg::P_RADDR:  ltx = {probe_addr_o, i2cme_pkg::DIR_RD};
        i2cme_pkg::P_MADDR:  ltx = msh_next[MW-1 -: 8];
        i2cme_pkg::P_RDATA:  lack = n_next != i2cme_pkg::NB_LAST;
        i2cme_pkg::P_WDATA: begin
          go        = 1'b0;
          wrdy_next = 1'b1;
        end
        default: go = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ph_reg        <= i2cme_pkg::P_IDLE;
      op_reg        <= i2cme_pkg::OP_PROBE;
      probe_addr_o  <= 7'h00;
      msh_reg       <= '0;
      mb_reg        <= 3'h0;
      n_reg         <= '0;
      count_o       <= '0;
      stop_reg      <= 1'b0;
      err_o         <= 1'b0;
      cmd_ready_o   <= 1'b1;
      cmd_refused_o <= 1'b0;
      wr_ready_o    <= 1'b0;
      rd_data_o     <= 8'h00;
      rd_valid_o    <= 1'b0;
      done_o        <= 1'b0;
      probe_hit_o   <= 1'b0;
    end else begin
      ph_reg        <= ph_next;
      op_reg        <= op_next;
      probe_addr_o  <= addr_next;
      msh_reg       <= msh_next;
      mb_reg        <= mb_next;
      n_reg         <= n_next;
      count_o       <= cnt_next;
      stop_reg      <= stop_next;
      err_o         <= err_next;
      cmd_ready_o   <= ready_next;
      cmd_refused_o <= refused_next;
      wr_ready_o    <= wrdy_next;
      rd_data_o     <= rdd_next;
      rd_valid_o    <= rdv_next;
      done_o        <= done_next;
      probe_hit_o   <= hit_next;
    end
  end
endmodule : i2cme_top
`default_nettype wire

/* File: dv/i2cme_monitor.sv */
// Checker of the engine command port and bus conditions
`default_nettype none
module i2cme_monitor #(
  parameter int unsigned QUARTER = i2cme_pkg::QUARTER_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ctrl_mode_i,
  input wire logic cmd_valid_i,
  input wire i2cme_pkg::i2cme_cmd_t cmd_i,
  input wire logic cmd_ready_o,
  input wire logic cmd_refused_o,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_valid_i,
  input wire logic wr_ready_o,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic done_o,
  input wire logic err_o,
  input wire logic [i2cme_pkg::NB_W-1:0] count_o,
  input wire logic probe_hit_o,
  input wire logic [6:0] probe_addr_o,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic scl_o,
  input wire logic scl_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic take = cmd_valid_i && cmd_ready_o;
  wire logic dlen = cmd_i.op >= i2cme_pkg::OP_RAW_RD && cmd_i.op <= i2cme_pkg::OP_MEM_WR;

  mode_refuse_a: assert property (take && !ctrl_mode_i |=> cmd_refused_o && cmd_ready_o)
    else $error("command taken outside controller mode");
  zero_refuse_a: assert property (take && ctrl_mode_i && dlen && cmd_i.nbytes == 16'h0000 |=> cmd_refused_o)
    else $error("empty transfer not refused");
  start_busy_a: assert property (take && ctrl_mode_i && cmd_i.op == i2cme_pkg::OP_START && cmd_i.mem_bits == 6'h00
                                 |=> !cmd_ready_o)
    else $error("start command not taken");
  start_cond_a: assert property ($rose(sda_oe_o) && !scl_oe_o |=> sda_oe_o ##[1:300] sda_oe_o && scl_oe_o)
    else $error("start condition malformed");
  stop_cond_a: assert property ($fell(sda_oe_o) && !scl_oe_o |=> !sda_oe_o && !scl_oe_o)
    else $error("stop condition malformed");
  probe_range_a: assert property (probe_hit_o |-> probe_addr_o >= 7'h08 && probe_addr_o <= 7'h77)
    else $error("probe hit outside address range");
  err_done_a: assert property ($rose(err_o) |-> done_o || !cmd_ready_o)
    else $error("error raised without completion");
  mode_idle_a: assert property (!ctrl_mode_i && cmd_ready_o && !scl_oe_o |=> !scl_oe_o && cmd_ready_o)
    else $error("bus activity outside controller mode");
  done_ready_a: assert property (done_o |-> cmd_ready_o && !$past(cmd_ready_o))
    else $error("completion without ready return");
endmodule : i2cme_monitor

bind i2cme_top i2cme_monitor #(.QUARTER(QUARTER)) mon (
  .clk_i(clk_i), .rst_i(rst_i), .ctrl_mode_i(ctrl_mode_i), .cmd_valid_i(cmd_valid_i),
  .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .cmd_refused_o(cmd_refused_o),
  .wr_data_i(wr_data_i), .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o),
  .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .done_o(done_o), .err_o(err_o),
  .count_o(count_o), .probe_hit_o(probe_hit_o), .probe_addr_o(probe_addr_o),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .scl_o(scl_o), .scl_oe_o(scl_oe_o));
`default_nettype wire

/* File: dv/i2cme_target.sv */
// Behavioural bus target answering the engine
`default_nettype none
module i2cme_target #(
  parameter logic [6:0] ADDR = 7'h42
) (
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      pull_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] adr_q[$];
  logic [7:0] got[$];
  logic       ack_q[$];
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = 8'h00;
  logic [7:0] k = 8'h00;
  logic [3:0] cnt = 4'h0;
  logic       act = 1'b0;
  logic       rd = 1'b0;
  logic       first = 1'b0;
  initial pull_o = 1'b0;
  // Start rearms address phase, stop drops out
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    first = 1'b1;
    act = 1'b0;
    cnt = 4'h0;
  end
  always @(posedge sda_i) if (scl_i === 1'b1) begin
    first = 1'b0;
    act = 1'b0;
    cnt = 4'h0;
  end
  // Sample bits, master not-acknowledge ends a read
  always @(posedge scl_i) begin
    if (cnt < 4'h8) begin
      sh = {sh[6:0], sda_i};
      cnt = cnt + 4'h1;
    end else begin
      cnt = 4'h0;
      if (act && rd && k != 8'h00) begin
        ack_q.push_back(sda_i);
        if (sda_i) act = 1'b0;
      end
    end
  end
  // Drive acknowledge and read data while SCL low
  always @(negedge scl_i) begin
    pull_o = 1'b0;
    if (cnt == 4'h8 && first) begin
      adr_q.push_back(sh);
      act = sh[7:1] == ADDR;
      rd = sh[0];
      first = 1'b0;
      k = 8'h00;
      pull_o = act;
    end else if (cnt == 4'h8 && act && !rd) begin
      got.push_back(sh);
      pull_o = 1'b1;
    end else if (cnt < 4'h8 && act && rd) begin
      if (cnt == 4'h0) tx = 8'ha0 + k;
      if (cnt == 4'h0) k = k + 8'h01;
      pull_o = ~tx[3'h7 - cnt[2:0]];
    end
  end
endmodule : i2cme_target
`default_nettype wire

/* File: dv/i2c_master_engine_bench.sv */
// Self-checking bench of the I2C controller engine
`default_nettype none
module i2c_master_engine_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] TA = 7'h42;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ctrl_mode_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  i2cme_pkg::i2cme_cmd_t cmd_i = '0;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_valid_i = 1'b0;
  logic cmd_ready_o, cmd_refused_o, wr_ready_o, rd_valid_o, done_o, err_o;
  logic probe_hit_o, sda_o, sda_oe_o, scl_o, scl_oe_o, pull;
  logic [7:0] rd_data_o;
  logic [15:0] count_o;
  logic [6:0] probe_addr_o, hit_a;
  wire logic scl_w = ~scl_oe_o;
  wire logic sda_w = ~(sda_oe_o | pull);
  logic [7:0] wq[$];
  logic [7:0] rd_q[$];
  logic refd;
  int hits, mismatches, tests_run;

  i2cme_top #(.QUARTER(2)) dut (.clk_i(clk_i), .rst_i(rst_i), .ctrl_mode_i(ctrl_mode_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .cmd_refused_o(cmd_refused_o),
    .wr_data_i(wr_data_i), .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .done_o(done_o), .err_o(err_o), .count_o(count_o),
    .probe_hit_o(probe_hit_o), .probe_addr_o(probe_addr_o), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .scl_o(scl_o), .scl_oe_o(scl_oe_o));
  i2cme_target #(.ADDR(TA)) tgt (.scl_i(scl_w), .sda_i(sda_w), .pull_o(pull));

  always #20 clk_i = ~clk_i;
  always @(negedge clk_i) if (probe_hit_o === 1'b1) begin
    hits++;
    hit_a = probe_addr_o;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  task automatic run(input i2cme_pkg::i2cme_op_t op, input logic [6:0] a, input logic [31:0] ma,
                     input logic [5:0] mb, input logic [15:0] nb, input logic st);
    int k;
    logic tk;
    rd_q = {};
    refd = 1'b0;
    tgt.adr_q = {};
    tgt.got = {};
    tgt.ack_q = {};
    cmd_i = '{op: op, addr: a, mem_addr: ma, mem_bits: mb, nbytes: nb, stop: st};
    cmd_valid_i = 1'b1;
    for (k = 0; k < 30000; k++) begin
      wr_valid_i = wq.size() > 0;
      wr_data_i = wq.size() > 0 ? wq[0] : 8'h00;
      @(negedge clk_i);
      tk = wr_valid_i && wr_ready_o;
      if (rd_valid_o === 1'b1) rd_q.push_back(rd_data_o);
      refd = cmd_refused_o === 1'b1;
      if (refd || done_o === 1'b1) break;
      @(posedge clk_i);
      #1 cmd_valid_i = 1'b0;
      if (tk) void'(wq.pop_front());
    end
    if (k == 30000) begin
      mismatches++;
      conclude();
    end
    @(posedge clk_i);
    #1 wr_valid_i = 1'b0;
    cmd_valid_i = 1'b0;
    @(negedge clk_i);
    if (rd_valid_o === 1'b1) rd_q.push_back(rd_data_o);
    @(posedge clk_i);
    #1;
  endtask : run

  task automatic t_refuse();
    int i;
    ctrl_mode_i = 1'b0;
    for (i = 0; i <= 8; i++) begin
      run(i2cme_pkg::i2cme_op_t'(i[3:0]), TA, 32'h0, 6'h00, 16'h0001, 1'b1);
      check(refd, 1'b1);
      check({scl_oe_o, sda_oe_o}, 2'b00);
    end
    ctrl_mode_i = 1'b1;
    run(i2cme_pkg::OP_RD, TA, 32'h0, 6'h00, 16'h0000, 1'b1);
    check(refd, 1'b1);
    run(i2cme_pkg::OP_MEM_RD, TA, 32'h0, 6'h03, 16'h0001, 1'b1);
    check(refd, 1'b1);
  endtask : t_refuse

  task automatic t_probe();
    hits = 0;
    run(i2cme_pkg::OP_PROBE, 7'h00, 32'h0, 6'h00, 16'h0000, 1'b1);
    check(hits, 1);
    check(hit_a, TA);
    check(tgt.adr_q.size(), 112);
    check(tgt.adr_q[0], 8'h11);
    check(tgt.adr_q[111], 8'hef);
  endtask : t_probe

  task automatic t_mem();
    wq = '{8'h5a, 8'hc3};
    run(i2cme_pkg::OP_MEM_WR, TA, 32'h1234, 6'h10, 16'h0002, 1'b1);
    check(tgt.got.size(), 4);
    check({tgt.got[0], tgt.got[1]}, 16'h1234);
    check({tgt.got[2], tgt.got[3]}, 16'h5ac3);
    check({err_o, count_o}, 17'h00002);
    run(i2cme_pkg::OP_MEM_RD, TA, 32'h07, 6'h00, 16'h0002, 1'b1);
    check({tgt.got.size(), tgt.got[0]}, {32'h1, 8'h07});
    check({tgt.adr_q[0], tgt.adr_q[1]}, {TA, 1'b0, TA, 1'b1});
    check({rd_q.size(), rd_q[0], rd_q[1]}, {32'h2, 16'ha0a1});
    check({tgt.ack_q[0], tgt.ack_q[1]}, 2'b01);
    check({count_o, scl_oe_o, sda_oe_o}, 18'h00008);
  endtask : t_mem

  task automatic t_hold();
    wq = '{8'h3c};
    run(i2cme_pkg::OP_WR, TA, 32'h0, 6'h00, 16'h0001, 1'b0);
    check({scl_oe_o, tgt.got[0]}, 9'h13c);
    run(i2cme_pkg::OP_STOP, TA, 32'h0, 6'h00, 16'h0000, 1'b1);
    check({scl_oe_o, sda_oe_o}, 2'b00);
    wq = '{8'h01, 8'h02};
    run(i2cme_pkg::OP_WR, TA, 32'h0, 6'h00, 16'h0002, 1'b1);
    check({count_o, scl_oe_o, sda_oe_o}, 18'h00008);
    run(i2cme_pkg::OP_RD, TA, 32'h0, 6'h00, 16'h0001, 1'b1);
    check({rd_q[0], tgt.ack_q[0]}, 9'h141);
    run(i2cme_pkg::OP_WR, 7'h11, 32'h0, 6'h00, 16'h0001, 1'b1);
    check({err_o, count_o, scl_oe_o, sda_oe_o}, 19'h40000);
  endtask : t_hold

  task automatic t_raw();
    run(i2cme_pkg::OP_START, TA, 32'h0, 6'h00, 16'h0000, 1'b1);
    check({scl_o, sda_o, scl_oe_o, sda_oe_o}, 4'b0011);
    wq = '{{TA, 1'b1}};
    run(i2cme_pkg::OP_RAW_WR, TA, 32'h0, 6'h00, 16'h0001, 1'b0);
    check(err_o, 1'b0);
    run(i2cme_pkg::OP_RAW_RD, TA, 32'h0, 6'h00, 16'h0003, 1'b0);
    check({rd_q.size(), rd_q[2], count_o}, {32'h3, 8'ha2, 16'h0003});
    check({tgt.ack_q[0], tgt.ack_q[1], tgt.ack_q[2]}, 3'b001);
    run(i2cme_pkg::OP_STOP, TA, 32'h0, 6'h00, 16'h0000, 1'b1);
    run(i2cme_pkg::OP_START, TA, 32'h0, 6'h00, 16'h0000, 1'b1);
    wq = '{8'h22};
    run(i2cme_pkg::OP_RAW_WR, TA, 32'h0, 6'h00, 16'h0001, 1'b0);
    check(err_o, 1'b1);
    run(i2cme_pkg::OP_STOP, TA, 32'h0, 6'h00, 16'h0000, 1'b1);
    check({scl_oe_o, sda_oe_o}, 2'b00);
  endtask : t_raw

  initial begin
    #(40 * 60000);
    mismatches++;
    conclude();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    #1 rst_i = 1'b0;
    t_refuse();
    t_probe();
    t_mem();
    t_hold();
    t_raw();
    conclude();
  end
endmodule : i2c_master_engine_bench
`default_nettype wire
